// File: include/nv_store_if.sv
// bundle between the command decoder and the nonvolatile word store
// assumes both ends share one clock, given to the modules separately
`timescale 1ns/1ps
interface nv_store_if;
   logic        wr_en;
   logic [3:0]  wr_addr;
   logic [15:0] wr_data;
   logic [3:0]  rd_addr;
   logic [15:0] rd_data;
   logic [15:0] wiper_word;

   modport ctrl (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data, input wiper_word);
   modport store (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data, output wiper_word);
endinterface : nv_store_if

// File: include/pot_pkg.sv
// constants and types shared by the serial command decoder and its store
// assumes a 24-bit frame, msb first, and a 10-bit wiper
package pot_pkg;

   // frame layout
   localparam int FRAME_BITS   = 24;
   localparam int CMD_MSB      = 23;
   localparam int CMD_LSB      = 20;
   localparam int ADDR_MSB     = 19;
   localparam int ADDR_LSB     = 16;
   localparam int DATA_MSB     = 15;
   localparam int DATA_LSB     = 0;
   localparam int DATA_BITS    = 16;
   localparam int POS_BITS     = 5;
   localparam logic [4:0] LAST_BIT_POS = 5'h17;
   localparam logic [4:0] FIRST_BIT_POS = 5'h00;

   // wiper
   localparam int WIPER_BITS   = 10;
   localparam logic [9:0] WIPER_ZERO  = 10'h000;
   localparam logic [9:0] WIPER_ONE   = 10'h001;
   localparam logic [9:0] WIPER_MID   = 10'h200;
   localparam logic [9:0] WIPER_FULL  = 10'h3ff;

   // nonvolatile store
   localparam int NV_WORDS     = 16;
   localparam int NV_ADDR_BITS = 4;
   localparam logic [3:0]  NV_WIPER_ADDR = 4'h0;
   localparam logic [15:0] NV_INIT_WORD  = 16'h0200;
   localparam logic [15:0] NV_INIT_USER  = 16'h0000;

   // command codes, one per 4-bit field value
   typedef enum logic [3:0] {
      CMD_NOP         = 4'b0000,
      CMD_RESTORE     = 4'b0001,
      CMD_STORE_WIPER = 4'b0010,
      CMD_STORE_WORD  = 4'b0011,
      CMD_HALVE       = 4'b0100,
      CMD_HALVE_ANY   = 4'b0101,
      CMD_DEC         = 4'b0110,
      CMD_DEC_ANY     = 4'b0111,
      CMD_RELOAD      = 4'b1000,
      CMD_READ_WORD   = 4'b1001,
      CMD_READ_WIPER  = 4'b1010,
      CMD_LOAD_WIPER  = 4'b1011,
      CMD_DOUBLE      = 4'b1100,
      CMD_DOUBLE_ANY  = 4'b1101,
      CMD_INC         = 4'b1110,
      CMD_INC_ANY     = 4'b1111
   } cmd_t;

endpackage : pot_pkg

// File: logic/nv_word_store.sv
// sixteen 16-bit words of nonvolatile storage modelled in flip-flops
// assumes the decoder writes at most one word per clock
`timescale 1ns/1ps
module nv_word_store (
   input  wire logic   i_ref_clk,
   input  wire logic   i_sys_rst,
   nv_store_if.store   bus
);

   logic [15:0] mem [pot_pkg::NV_WORDS];

   // reset stands in for the programmed contents at power-up
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         for (int i = 0; i < pot_pkg::NV_WORDS; i++)
         begin
            mem[i] <= pot_pkg::NV_INIT_USER;
         end
         mem[pot_pkg::NV_WIPER_ADDR] <= pot_pkg::NV_INIT_WORD;
      end
      else if (bus.wr_en)
      begin
         mem[bus.wr_addr] <= bus.wr_data;
      end
   end

   // reads are combinational so a restore lands in one clock
   assign bus.rd_data    = mem[bus.rd_addr];
   assign bus.wiper_word = mem[pot_pkg::NV_WIPER_ADDR];

endmodule : nv_word_store

// File: logic/pot_serial_command_decoder.sv
// serial command decoder of a 1024-position nonvolatile potentiometer
// assumes a slow spi host (mode 0 or 3) sampled by the 25 MHz clock
//
// Functional notes
// - frame is 24 bits msb first: command, address, 16 data bits
// - command 0 does nothing and leaves the read program state
// - command 1 at address 0 copies store word 0 into the wiper
// - after command 1 the read program state holds until a nop
// - command 2 writes the wiper into store word 0
// - command 3 writes 16 data bits to the addressed store word
// - store word 0 gives its low 10 bits as wiper position
// - commands 4 and 5 halve the wiper; 5 ignores address
// - commands 6 and 7 step the wiper down; 7 ignores address
// - command 8 reloads the wiper from store word 0, any address
// - command 9 returns the addressed store word in next frame
// - command 10 returns the wiper value in the next frame
// - command 11 loads the low 10 data bits into the wiper
// - commands 12 and 13 double the wiper; 13 ignores address
// - commands 14 and 15 step the wiper up; 15 needs no address
// - serial out shifts out the previous 24 received bits
// - after a read the data bytes carry the requested value
// - wiper is volatile and loads from the store at power-up
// - commands execute only when chip select rises
// - step and shift commands ignore the data bits
// - doubling is a left shift, halving a right shift
// - doubling zero gives one; at or above midscale gives 1023
// - only whole 24-bit frames execute; counter clears at select rise
`timescale 1ns/1ps
module pot_serial_command_decoder (
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_serial_clk,
   input  wire logic       i_chip_select_n,
   input  wire logic       i_serial_in,
   output logic [9:0]      o_wiper,
   output logic            o_read_program_state,
   output logic            o_serial_out,
   output logic            o_serial_out_oe
);

   // doubling with the end points fixed up
   function automatic logic [9:0] wiper_double(input logic [9:0] w);
      logic [9:0] r;
      r = {w[8:0], 1'b0};
      if (w == pot_pkg::WIPER_ZERO)
         r = pot_pkg::WIPER_ONE;
      else if (w >= pot_pkg::WIPER_MID)
         r = pot_pkg::WIPER_FULL;
      return r;
   endfunction : wiper_double

   // halving drops the lsb, so zero stays zero
   function automatic logic [9:0] wiper_halve(input logic [9:0] w);
      return {1'b0, w[9:1]};
   endfunction : wiper_halve

   // single steps saturate instead of wrapping
   function automatic logic [9:0] wiper_up(input logic [9:0] w);
      return (w == pot_pkg::WIPER_FULL) ? w : w + pot_pkg::WIPER_ONE;
   endfunction : wiper_up

   function automatic logic [9:0] wiper_down(input logic [9:0] w);
      return (w == pot_pkg::WIPER_ZERO) ? w : w - pot_pkg::WIPER_ONE;
   endfunction : wiper_down

   // codes that run whatever the address field holds
   function automatic logic ignores_addr(input pot_pkg::cmd_t c);
      logic r;
      r = 1'b0;
      case (c)
         pot_pkg::CMD_NOP, pot_pkg::CMD_STORE_WORD,
         pot_pkg::CMD_HALVE_ANY, pot_pkg::CMD_DEC_ANY,
         pot_pkg::CMD_RELOAD, pot_pkg::CMD_READ_WORD,
         pot_pkg::CMD_DOUBLE_ANY, pot_pkg::CMD_INC_ANY:
            r = 1'b1;
         default:
            r = 1'b0;
      endcase
      return r;
   endfunction : ignores_addr

   // pin synchronisers; bit 2 is history for edge detection only
   logic [2:0]  sclk_sync;
   logic [2:0]  cs_sync;
   logic [1:0]  sin_sync;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_rise;
   logic        cs_fall;
   logic        cs_low;

   // frame state
   logic [23:0] frame_sh;
   logic [4:0]  bit_pos;
   logic        bits_seen;
   logic        frame_done;
   logic        exec;
   logic        go;
   logic        out_bit;

   // decoded fields
   pot_pkg::cmd_t cmd;
   logic [3:0]  addr;
   logic [15:0] data;
   logic        addr_ok;
   logic        is_store;
   logic        is_read;
   logic        read_go;
   logic [15:0] readback;

   // wiper and power state
   logic [9:0]  wiper;
   logic [9:0]  next_wiper;
   logic        read_program;
   logic        boot;
   logic [9:0]  stored_wiper;

   nv_store_if nv ();

   nv_word_store u_store (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .bus       (nv.store)
   );

   // two flops before any logic sees a pin
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         sclk_sync <= 3'h0;
         cs_sync   <= 3'h7;
         sin_sync  <= 2'h0;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], i_serial_clk};
         cs_sync   <= {cs_sync[1:0], i_chip_select_n};
         sin_sync  <= {sin_sync[0], i_serial_in};
      end
   end

   // edges seen only from the second flop onward
   assign cs_low    = ~cs_sync[1];
   assign cs_rise   = cs_sync[1] & ~cs_sync[2];
   assign cs_fall   = ~cs_sync[1] & cs_sync[2];
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2] & cs_low;
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2] & cs_low;

   // field split of the last 24 bits received
   assign cmd  = pot_pkg::cmd_t'(frame_sh[pot_pkg::CMD_MSB:pot_pkg::CMD_LSB]);
   assign addr = frame_sh[pot_pkg::ADDR_MSB:pot_pkg::ADDR_LSB];
   assign data = frame_sh[pot_pkg::DATA_MSB:pot_pkg::DATA_LSB];

   // only a whole number of frames executes, and only at select rise
   assign frame_done = bits_seen && (bit_pos == pot_pkg::FIRST_BIT_POS);
   assign exec       = cs_rise && frame_done;
   assign addr_ok    = (addr == pot_pkg::NV_WIPER_ADDR) || ignores_addr(cmd);
   assign go         = exec && addr_ok;

   // store and readback decode
   assign is_store = (cmd == pot_pkg::CMD_STORE_WIPER) ||
                     (cmd == pot_pkg::CMD_STORE_WORD);
   assign is_read  = (cmd == pot_pkg::CMD_READ_WORD) ||
                     (cmd == pot_pkg::CMD_READ_WIPER);
   assign read_go  = go && is_read;
   assign readback = (cmd == pot_pkg::CMD_READ_WIPER) ?
                     16'(wiper) : nv.rd_data;

   // store port: wiper goes to word 0, data words to the addressed slot
   assign nv.wr_en   = go && is_store;
   assign nv.wr_addr = (cmd == pot_pkg::CMD_STORE_WIPER) ?
                       pot_pkg::NV_WIPER_ADDR : addr;
   assign nv.wr_data = (cmd == pot_pkg::CMD_STORE_WIPER) ?
                       16'(wiper) : data;
   assign nv.rd_addr = addr;

   // only the low bits of word 0 mean anything as a position
   assign stored_wiper = nv.wiper_word[pot_pkg::WIPER_BITS-1:0];

   // wiper update; step and shift codes never look at data
   always_comb
   begin
      next_wiper = wiper;
      if (boot)
         next_wiper = stored_wiper;
      else if (go)
      begin
         unique case (cmd)
            pot_pkg::CMD_RESTORE, pot_pkg::CMD_RELOAD:
               next_wiper = stored_wiper;
            pot_pkg::CMD_HALVE, pot_pkg::CMD_HALVE_ANY:
               next_wiper = wiper_halve(wiper);
            pot_pkg::CMD_DEC, pot_pkg::CMD_DEC_ANY:
               next_wiper = wiper_down(wiper);
            pot_pkg::CMD_LOAD_WIPER:
               next_wiper = data[pot_pkg::WIPER_BITS-1:0];
            pot_pkg::CMD_DOUBLE, pot_pkg::CMD_DOUBLE_ANY:
               next_wiper = wiper_double(wiper);
            pot_pkg::CMD_INC, pot_pkg::CMD_INC_ANY:
               next_wiper = wiper_up(wiper);
            pot_pkg::CMD_NOP, pot_pkg::CMD_STORE_WIPER,
            pot_pkg::CMD_STORE_WORD, pot_pkg::CMD_READ_WORD,
            pot_pkg::CMD_READ_WIPER:
               next_wiper = wiper;
         endcase
      end
   end

   // wiper and the one-shot power-up load
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wiper <= pot_pkg::WIPER_ZERO;
         boot  <= 1'b1;
      end
      else
      begin
         wiper <= next_wiper;
         boot  <= 1'b0;
      end
   end

   // read program state: entered by restore, left only by nop
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         read_program <= 1'b0;
      else if (go && cmd == pot_pkg::CMD_RESTORE)
         read_program <= 1'b1;
      else if (go && cmd == pot_pkg::CMD_NOP)
         read_program <= 1'b0;
   end

   // bit counter; any select rise clears it, so a short frame is lost
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         bit_pos   <= pot_pkg::FIRST_BIT_POS;
         bits_seen <= 1'b0;
      end
      else if (cs_rise)
      begin
         bit_pos   <= pot_pkg::FIRST_BIT_POS;
         bits_seen <= 1'b0;
      end
      else if (sclk_rise)
      begin
         bits_seen <= 1'b1;
         bit_pos   <= (bit_pos == pot_pkg::LAST_BIT_POS) ?
                      pot_pkg::FIRST_BIT_POS :
                      bit_pos + 5'h01;
      end
   end

   // one register both receives and replays the frame, which is what
   // makes chaining work; a read overwrites its data bytes at execute
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         frame_sh <= 24'h000000;
      else if (read_go)
         frame_sh[pot_pkg::DATA_MSB:pot_pkg::DATA_LSB] <= readback;
      else if (sclk_rise)
         frame_sh <= {frame_sh[22:0], sin_sync[1]};
   end

   // output bit changes on falling clock so the host samples it rising;
   // a host that sends a short frame after a read loses the tail
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         out_bit <= 1'b1;
      else if (cs_fall || sclk_fall)
         out_bit <= frame_sh[pot_pkg::CMD_MSB];
   end

   // open drain: drive only a low, and only while selected
   assign o_serial_out         = out_bit;
   assign o_serial_out_oe      = cs_low & ~out_bit;
   assign o_wiper              = wiper;
   assign o_read_program_state = read_program;

   // checks kept beside the logic they watch

   property p_exec_only_at_rise;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      exec |-> cs_sync[1] && !cs_sync[2] && bit_pos == 5'h00;
   endproperty
   a_exec_only_at_rise: assert property (p_exec_only_at_rise)
      else $error("command executed outside a select rise");

   property p_nop_leaves_state;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_NOP |=> !o_read_program_state;
   endproperty
   a_nop_leaves_state: assert property (p_nop_leaves_state)
      else $error("nop did not return to idle");

   property p_restore;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_RESTORE |=>
         o_wiper == $past(stored_wiper) && o_read_program_state;
   endproperty
   a_restore: assert property (p_restore)
      else $error("restore did not load wiper or enter read state");

   property p_state_holds;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_read_program_state && !(go && cmd == pot_pkg::CMD_NOP)
         |=> o_read_program_state;
   endproperty
   a_state_holds: assert property (p_state_holds)
      else $error("read program state left without a nop");

   property p_store_wiper;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_STORE_WIPER |=>
         nv.wiper_word == 16'($past(wiper));
   endproperty
   a_store_wiper: assert property (p_store_wiper)
      else $error("wiper not stored to word 0");

   property p_halve;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && (cmd == pot_pkg::CMD_HALVE || cmd == pot_pkg::CMD_HALVE_ANY)
         |=> o_wiper == ($past(wiper) >> 1);
   endproperty
   a_halve: assert property (p_halve)
      else $error("halving gave a wrong wiper");

   property p_step_down;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_DEC_ANY && wiper != 10'h000
         |=> o_wiper == $past(wiper) - 10'h001;
   endproperty
   a_step_down: assert property (p_step_down)
      else $error("step down gave a wrong wiper");

   property p_double_ends;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_DOUBLE && wiper >= 10'h200
         |=> o_wiper == 10'h3ff;
   endproperty
   a_double_ends: assert property (p_double_ends)
      else $error("doubling above midscale did not reach full scale");

   property p_step_up_sat;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_INC_ANY && wiper == 10'h3ff
         |=> o_wiper == 10'h3ff;
   endproperty
   a_step_up_sat: assert property (p_step_up_sat)
      else $error("step up wrapped past full scale");

   property p_load;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_LOAD_WIPER |=>
         o_wiper == $past(data[9:0]);
   endproperty
   a_load: assert property (p_load)
      else $error("direct load did not reach the wiper");

   property p_read_wiper;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      go && cmd == pot_pkg::CMD_READ_WIPER |=>
         frame_sh[15:0] == 16'($past(wiper)) ##1 !sclk_rise [*2];
   endproperty
   a_read_wiper: assert property (p_read_wiper)
      else $error("wiper readback not placed in data bytes");

   property p_boot_load;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      boot |=> o_wiper == $past(stored_wiper);
   endproperty
   a_boot_load: assert property (p_boot_load)
      else $error("wiper not loaded from store after reset");

endmodule : pot_serial_command_decoder

// File: verif/pot_serial_command_decoder_tb.sv
// self-checking bench of the serial command decoder
// assumes the spi host model drives all serial pins at falling edges
`timescale 1ns/1ps
module pot_serial_command_decoder_tb;
   logic        ref_clk;
   logic        sys_rst;
   logic        serial_clk;
   logic        chip_select_n;
   logic        serial_in;
   logic [9:0]  wiper;
   logic        rp_state;
   logic        sout;
   logic        sout_oe;
   wire         serial_line;
   logic [23:0] rx;
   logic [47:0] wide;
   int          bad_count;
   int          checks_done;

   // open drain with pull-up: only the enable decides the level
   assign serial_line = sout_oe ? 1'b0 : 1'b1;

   always #20 ref_clk = ~ref_clk;

   pot_serial_command_decoder pot_serial_command_decoder_inst (
      .i_ref_clk            (ref_clk),
      .i_sys_rst            (sys_rst),
      .i_serial_clk         (serial_clk),
      .i_chip_select_n      (chip_select_n),
      .i_serial_in          (serial_in),
      .o_wiper              (wiper),
      .o_read_program_state (rp_state),
      .o_serial_out         (sout),
      .o_serial_out_oe      (sout_oe)
   );

   spi_host_model spi_host_model_inst (
      .i_ref_clk       (ref_clk),
      .i_serial_line   (serial_line),
      .o_serial_clk    (serial_clk),
      .o_chip_select_n (chip_select_n),
      .o_serial_in     (serial_in)
   );

   task automatic check(input string name, input logic [23:0] seen,
                        input logic [23:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   task automatic send(input logic [23:0] tx);
      spi_host_model_inst.frame(tx, rx);
   endtask : send

   task automatic load(input logic [9:0] v);
      send({8'hb0, 6'h00, v});
   endtask : load

   task automatic test_reset();
      check("reset wiper", wiper, 24'h000200);
      check("reset state", rp_state, 24'h000000);
      check("idle enable", sout_oe, 24'h000000);
   endtask : test_reset

   // nothing moves until select rises; high data bits are dropped
   task automatic test_load();
      spi_host_model_inst.shift(48'h0000_00b0fd55, 24, wide);
      check("wiper mid frame", wiper, 24'h000200);
      spi_host_model_inst.finish();
      check("load wiper", wiper, 24'h000155);
      send(24'hb30077);
      check("load bad address", wiper, 24'h000155);
   endtask : test_load

   // every step and shift code, data bits all ones to show they are unused
   task automatic test_steps();
      logic [7:0] op [11];
      logic [9:0] from [11];
      logic [9:0] to [11];
      op   = '{8'he0, 8'hf5, 8'h60, 8'h7a, 8'hc0, 8'hd9, 8'hc0, 8'h40,
               8'h50, 8'h5c, 8'he3};
      from = '{10'h3ff, 10'h100, 10'h000, 10'h101, 10'h000, 10'h200,
               10'h0c1, 10'h3ff, 10'h000, 10'h003, 10'h010};
      to   = '{10'h3ff, 10'h101, 10'h000, 10'h100, 10'h001, 10'h3ff,
               10'h182, 10'h1ff, 10'h000, 10'h001, 10'h010};
      for (int i = 0; i < 11; i++)
      begin
         load(from[i]);
         send({op[i], 16'hffff});
         check("step", wiper, {14'h0000, to[i]});
      end
   endtask : test_steps

   // store, reload, restore and the read program state
   task automatic test_store();
      load(10'h2a5);
      send(24'h200000);
      load(10'h011);
      send(24'h871234);
      check("reload", wiper, 24'h0002a5);
      send(24'h30fc33);
      check("store word 0", wiper, 24'h0002a5);
      send(24'h100000);
      check("restore", wiper, 24'h000033);
      check("state set", rp_state, 24'h000001);
      load(10'h001);
      check("state held", rp_state, 24'h000001);
      send(24'h000000);
      check("state cleared", rp_state, 24'h000000);
   endtask : test_store

   // readback replaces the data bytes of the next frame only
   task automatic test_readback();
      load(10'h155);
      send(24'h37beef);
      send(24'h970000);
      send(24'h0a1234);
      check("read word", rx, 24'h97beef);
      send(24'ha00000);
      check("chain out", rx, 24'h0a1234);
      send(24'h000000);
      check("read wiper", rx, 24'ha00155);
      check("released out", sout_oe, 24'h000000);
   endtask : test_readback

   // only whole multiples of 24 bits execute, the last 24 counting
   task automatic test_framing();
      load(10'h0aa);
      spi_host_model_inst.shift(48'h0000_00b00123, 23, wide);
      spi_host_model_inst.finish();
      check("23 bits", wiper, 24'h0000aa);
      spi_host_model_inst.shift(48'h0000_00b00123, 25, wide);
      spi_host_model_inst.finish();
      check("25 bits", wiper, 24'h0000aa);
      spi_host_model_inst.shift(48'hf00000_b00123, 48, wide);
      spi_host_model_inst.finish();
      check("48 bits", wiper, 24'h000123);
      spi_host_model_inst.shift(48'h0, 0, wide);
      spi_host_model_inst.finish();
      check("bare select", wiper, 24'h000123);
   endtask : test_framing

   // main sequence
   initial
   begin
      ref_clk     = 1'b0;
      sys_rst     = 1'b1;
      bad_count   = 0;
      checks_done = 0;
      repeat (16) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      test_reset();
      test_load();
      test_steps();
      test_store();
      test_readback();
      test_framing();
      complete_run();
   end

   // about 45 frames of 310 clocks each; allow four times that
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      complete_run();
   end
endmodule : pot_serial_command_decoder_tb

// File: verif/spi_host_model.sv
// spi host model that shifts mode 0 frames into the decoder
// assumes the open-drain serial out line is resolved with its pull-up
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic i_ref_clk,
   input  wire logic i_serial_line,
   output logic      o_serial_clk,
   output logic      o_chip_select_n,
   output logic      o_serial_in
);
   // each serial clock level lasts 6 ref clocks, above the 4 the decoder needs
   localparam int HALF = 6;

   // idle: clock stands low, select released
   initial
   begin
      o_serial_clk    = 1'b0;
      o_chip_select_n = 1'b1;
      o_serial_in     = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask : wait_clk

   // sends the low n bits of tx msb first, select held low afterwards
   task automatic shift(input logic [47:0] tx, input int n,
                        output logic [47:0] rx);
      rx = '0;
      wait_clk(1);
      o_chip_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         o_serial_in = tx[i];
         wait_clk(HALF);
         rx = {rx[46:0], i_serial_line};
         o_serial_clk = 1'b1;
         wait_clk(HALF);
         o_serial_clk = 1'b0;
      end
      wait_clk(HALF);
   endtask : shift

   // raising select launches the command; data line shows junk meanwhile
   task automatic finish();
      o_serial_in     = ~o_serial_in;
      o_chip_select_n = 1'b1;
      wait_clk(10);
   endtask : finish

   // a whole 24-bit frame, also the one that drains a readback
   task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
      logic [47:0] wide;
      shift({24'h000000, tx}, 24, wide);
      finish();
      rx = wide[23:0];
   endtask : frame
endmodule : spi_host_model
